// ==== rtl/epmi_pkg.sv ====
// Purpose: shared constants and types for the external PHY model that faces the MAC's media pins
// Assumes: ref_clk_in at 100 MHz; link clocks made here by division
// Notes: device map constants describe the MAC outside and are not implemented here
package epmi_pkg;
    // device register map (the MAC outside); selects external media mode
    localparam logic [7:0] DEV_INTERNAL_PHY_USE_CONTROL = 8'h01;
    localparam logic [7:0] DEV_MEDIA_INTERFACE_SELECT = 8'h81;
    localparam int DEV_MEDIA_SEL_LSB = 2;
    localparam logic [2:0] DEV_MEDIA_SEL_EXTERNAL = 3'h1;
    localparam int DEV_PHY_USE_BIT = 2;
    localparam logic [4:0] DEV_INTERNAL_PHY_ADDR = 5'h01;
    localparam logic [4:0] PHY_ADDR_RESET = 5'h02;

    // link clock rates and the derived half periods in reference cycles
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int RATE_100M_HZ = 25_000_000;
    localparam int RATE_10M_HZ = 2_500_000;
    localparam int RATE_1M_HZ = 250_000;
    localparam logic [7:0] HALF_100M = 8'(REF_CLK_HZ / (2 * RATE_100M_HZ));
    localparam logic [7:0] HALF_10M = 8'(REF_CLK_HZ / (2 * RATE_10M_HZ));
    localparam logic [7:0] HALF_1M = 8'(REF_CLK_HZ / (2 * RATE_1M_HZ));

    // own register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_RX_NIB = 8'h0C;
    localparam logic [7:0] REG_TX_NIB = 8'h10;
    localparam logic [7:0] REG_PHY_ADDR = 8'h14;
    localparam logic [7:0] REG_MII_DATA = 8'h18;

    // control bits
    localparam int CTRL_LINK = 0;
    localparam int CTRL_TEN_MEG = 1;
    localparam int CTRL_ONE_MEG = 2;
    localparam int CTRL_CARRIER = 3;
    localparam int CTRL_COLLIDE = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // status and mask bits
    localparam int EV_TX_NIB = 0;
    localparam int EV_TX_END = 1;
    localparam int EV_RX_TAKEN = 2;
    localparam int EV_MD_WRITE = 3;
    localparam int EV_MD_READ = 4;
    localparam int EV_LINK = 5;
    localparam logic [5:0] STAT_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;

    // receive and transmit nibble and management data register fields
    localparam int RXN_ERR = 4;
    localparam int RXN_FULL = 5;
    localparam int RXN_DV = 6;
    localparam int TXN_EN = 4;
    localparam int TXN_CNT_LSB = 8;
    localparam int MII_ADDR_LSB = 16;

    // management frame counts and codes
    localparam logic [5:0] MD_PRE_ONES = 6'h20;
    localparam logic [5:0] MD_HDR_LAST = 6'h0C;
    localparam logic [5:0] MD_DATA_LAST = 6'h0F;
    localparam logic [5:0] MD_SKIP_LAST = 6'h11;
    localparam logic [1:0] MD_OP_READ = 2'h2;
    localparam logic [1:0] MD_OP_WRITE = 2'h1;

    typedef enum logic [2:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA, MD_SKIP} epmi_md_state_t;

    typedef struct packed {
        logic en;
        logic [3:0] d;
    } epmi_tx_pins_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] d;
    } epmi_rx_pins_t;
endpackage : epmi_pkg

// ==== rtl/epmi_mgmt_ram.sv ====
// Purpose: management register file of the modelled PHY
// Assumes: one write port, one read port, read data registered
// Notes: array itself has no reset; contents are undefined until written
`timescale 1ns/1ps
module epmi_mgmt_ram #(
    parameter int DW = 16,
    parameter int AW = 5
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_ff;

    always_ff @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= mem[raddr_in];
        end
    end

    assign rdata_out = rdata_ff;
endmodule : epmi_mgmt_ram

// ==== rtl/epmi_phy.sv ====
// Purpose: external PHY model driving the MAC's media pins and answering management frames
// Assumes: MAC drives tx pins and mdc from its own clocks; all such inputs are synchronised here
// Notes: link clocks are made by division of ref_clk_in and run free in every mode
`timescale 1ns/1ps
// Summary of operation
// - collision output goes high and stays high for the whole collision.
// - carrier sense output goes high whenever the medium is not idle.
// - one shared management data line, driven by each side in turn.
// - free-running receive clock at 25, 2.5 or 0.25 MHz by speed.
// - receive nibbles change with the receive clock, bit 3 most significant.
// - receive data valid marks exactly the cycles carrying decoded nibbles.
// - receive error only while data valid is high, marks the frame errored.
// - continuous transmit clock at 25, 2.5 or 0.25 MHz by speed.
// - link state output; every level change is an event for the MAC.
// - in phone-line one meg mode collision uses the shared collision output.
// - in phone-line one meg mode carrier uses the shared carrier output.
module epmi_phy #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rd_data_out,
    output logic irq_out,
    input wire epmi_pkg::epmi_tx_pins_t tx_pins_in,
    output logic tx_clk_out,
    output logic rx_clk_out,
    output epmi_pkg::epmi_rx_pins_t rx_pins_out,
    output logic carrier_out,
    output logic collision_out,
    output logic ext_link_state_out,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out
);
    typedef struct packed {
        logic [4:0] ctrl;
        logic [5:0] stat;
        logic [5:0] mask;
        logic [4:0] phy_addr;
        logic [3:0] rx_hold;
        logic rx_hold_err;
        logic rx_hold_full;
        epmi_pkg::epmi_rx_pins_t rx_pins;
        logic carrier;
        logic collision;
        logic link;
        logic [7:0] div_cnt;
        logic lclk;
        epmi_pkg::epmi_tx_pins_t tx_s1;
        epmi_pkg::epmi_tx_pins_t tx_s2;
        logic tx_prev_en;
        logic [3:0] tx_last;
        logic [7:0] tx_cnt;
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_prev;
        logic mdio_s1;
        logic mdio_s2;
        logic md_out;
        logic md_oe;
        epmi_pkg::epmi_md_state_t md_state;
        logic [5:0] md_cnt;
        logic [15:0] md_shift;
        logic md_read;
        logic [4:0] md_reg;
        logic [20:0] mii_last;
        logic [DATA_W-1:0] rd_data;
        logic irq;
    } epmi_phy_state_t;

    epmi_phy_state_t st_ff;
    epmi_phy_state_t nxt_st;
    logic mem_we;
    logic [4:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;

    function automatic logic [7:0] half_period(input logic [4:0] ctrl);
        if (ctrl[epmi_pkg::CTRL_ONE_MEG]) begin
            half_period = epmi_pkg::HALF_1M;
        end else if (ctrl[epmi_pkg::CTRL_TEN_MEG]) begin
            half_period = epmi_pkg::HALF_10M;
        end else begin
            half_period = epmi_pkg::HALF_100M;
        end
    endfunction : half_period

    epmi_mgmt_ram #(.DW(16), .AW(5)) u_ram (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(st_ff.md_reg),
        .rdata_out(mem_rdata)
    );

    always_comb begin
        logic lrise;
        logic lfall;
        logic mdc_rise;
        logic [5:0] ev;
        logic [12:0] hdr;
        nxt_st = st_ff;
        lrise = 1'b0;
        mdc_rise = st_ff.mdc_s2 & ~st_ff.mdc_prev;
        lfall = 1'b0;
        ev = '0;
        hdr = {st_ff.md_shift[11:0], st_ff.mdio_s2};
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        nxt_st.rd_data = '0;
        // pin inputs: first stage feeds only the second
        nxt_st.tx_s1 = tx_pins_in;
        nxt_st.tx_s2 = st_ff.tx_s1;
        nxt_st.mdc_s1 = mdc_in;
        nxt_st.mdc_s2 = st_ff.mdc_s1;
        nxt_st.mdc_prev = st_ff.mdc_s2;
        nxt_st.mdio_s1 = mdio_in;
        nxt_st.mdio_s2 = st_ff.mdio_s1;

        // free-running link clock; a slower speed simply lets the count run longer
        if (st_ff.div_cnt >= half_period(st_ff.ctrl) - 8'h01) begin
            nxt_st.div_cnt = '0;
            nxt_st.lclk = ~st_ff.lclk;
            lrise = ~st_ff.lclk;
            lfall = st_ff.lclk;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
        end

        // receive side changes on the falling edge so the MAC samples a settled nibble
        if (lfall) begin
            if (st_ff.rx_hold_full) begin
                nxt_st.rx_pins.d = st_ff.rx_hold;
                nxt_st.rx_pins.dv = 1'b1;
                nxt_st.rx_pins.er = st_ff.rx_hold_err;
                nxt_st.rx_hold_full = 1'b0;
                ev[epmi_pkg::EV_RX_TAKEN] = 1'b1;
            end else begin
                nxt_st.rx_pins = '0; // frame ends when software stops feeding
            end
        end

        // transmit side: synchronised pins sampled at our own rising edge
        if (lrise) begin
            nxt_st.tx_prev_en = st_ff.tx_s2.en;
            if (st_ff.tx_s2.en) begin
                nxt_st.tx_last = st_ff.tx_s2.d;
                nxt_st.tx_cnt = st_ff.tx_prev_en ? st_ff.tx_cnt + 8'h01 : 8'h01;
                ev[epmi_pkg::EV_TX_NIB] = 1'b1;
            end else if (st_ff.tx_prev_en) begin
                ev[epmi_pkg::EV_TX_END] = 1'b1;
            end
        end

        // medium state; the same pins serve the phone-line one meg mode
        nxt_st.carrier = st_ff.ctrl[epmi_pkg::CTRL_CARRIER] | nxt_st.rx_pins.dv
                         | st_ff.tx_s2.en;
        nxt_st.collision = st_ff.ctrl[epmi_pkg::CTRL_COLLIDE]
                           | (nxt_st.rx_pins.dv & st_ff.tx_s2.en);
        nxt_st.link = st_ff.ctrl[epmi_pkg::CTRL_LINK];
        ev[epmi_pkg::EV_LINK] = st_ff.ctrl[epmi_pkg::CTRL_LINK] != st_ff.link;

        // management frame receiver and answerer
        if (mdc_rise) begin
            case (st_ff.md_state)
                epmi_pkg::MD_PRE: begin
                    if (st_ff.mdio_s2) begin
                        if (st_ff.md_cnt < epmi_pkg::MD_PRE_ONES) begin
                            nxt_st.md_cnt = st_ff.md_cnt + 6'h01;
                        end
                    end else if (st_ff.md_cnt == epmi_pkg::MD_PRE_ONES) begin
                        nxt_st.md_state = epmi_pkg::MD_HDR;
                        nxt_st.md_cnt = '0;
                    end else begin
                        nxt_st.md_cnt = '0;
                    end
                end
                epmi_pkg::MD_HDR: begin
                    nxt_st.md_shift = {st_ff.md_shift[14:0], st_ff.mdio_s2};
                    nxt_st.md_cnt = st_ff.md_cnt + 6'h01;
                    if (st_ff.md_cnt == epmi_pkg::MD_HDR_LAST) begin
                        nxt_st.md_cnt = '0;
                        nxt_st.md_reg = hdr[4:0];
                        nxt_st.md_read = hdr[11:10] == epmi_pkg::MD_OP_READ;
                        // address 1 belongs to the MAC's internal PHY, never answered here
                        if (hdr[12] && hdr[9:5] == st_ff.phy_addr && hdr[9:5] != epmi_pkg::DEV_INTERNAL_PHY_ADDR
                            && (hdr[11:10] == epmi_pkg::MD_OP_READ
                            || hdr[11:10] == epmi_pkg::MD_OP_WRITE)) begin
                            nxt_st.md_state = epmi_pkg::MD_TA;
                        end else begin
                            nxt_st.md_state = epmi_pkg::MD_SKIP;
                        end
                    end
                end
                epmi_pkg::MD_TA: begin
                    nxt_st.md_cnt = st_ff.md_cnt + 6'h01;
                    if (st_ff.md_cnt == 6'h00) begin
                        nxt_st.md_oe = st_ff.md_read;
                        nxt_st.md_out = 1'b0;
                    end else begin
                        nxt_st.md_state = epmi_pkg::MD_DATA;
                        nxt_st.md_cnt = '0;
                        nxt_st.md_out = mem_rdata[15];
                        nxt_st.md_shift = {mem_rdata[14:0], 1'b0};
                    end
                end
                epmi_pkg::MD_DATA: begin
                    nxt_st.md_cnt = st_ff.md_cnt + 6'h01;
                    if (st_ff.md_read) begin
                        nxt_st.md_out = st_ff.md_shift[15];
                        nxt_st.md_shift = {st_ff.md_shift[14:0], 1'b0};
                    end else begin
                        nxt_st.md_shift = {st_ff.md_shift[14:0], st_ff.mdio_s2};
                    end
                    if (st_ff.md_cnt == epmi_pkg::MD_DATA_LAST) begin
                        nxt_st.md_state = epmi_pkg::MD_PRE;
                        nxt_st.md_cnt = '0;
                        nxt_st.md_oe = 1'b0; // line handed back after the last bit
                        nxt_st.md_out = 1'b0;
                        if (st_ff.md_read) begin
                            ev[epmi_pkg::EV_MD_READ] = 1'b1;
                        end else begin
                            ev[epmi_pkg::EV_MD_WRITE] = 1'b1;
                            nxt_st.mii_last = {st_ff.md_reg, st_ff.md_shift[14:0], st_ff.mdio_s2};
                        end
                    end
                end
                epmi_pkg::MD_SKIP: begin
                    nxt_st.md_cnt = st_ff.md_cnt + 6'h01;
                    if (st_ff.md_cnt == epmi_pkg::MD_SKIP_LAST) begin
                        nxt_st.md_state = epmi_pkg::MD_PRE;
                        nxt_st.md_cnt = '0;
                    end
                end
                default: begin
                    nxt_st.md_state = epmi_pkg::MD_PRE;
                    nxt_st.md_cnt = '0;
                    nxt_st.md_oe = 1'b0;
                end
            endcase
        end

        // software side
        if (wr_in) begin
            case (addr_in)
                epmi_pkg::REG_CTRL: nxt_st.ctrl = wr_data_in[4:0];
                epmi_pkg::REG_MASK: nxt_st.mask = wr_data_in[5:0];
                epmi_pkg::REG_PHY_ADDR: nxt_st.phy_addr = wr_data_in[4:0];
                epmi_pkg::REG_RX_NIB: begin
                    // one holding slot only: a write while it is full is dropped,
                    // but one landing as the slot drains is kept, so the set wins
                    if (!st_ff.rx_hold_full || lfall) begin
                        nxt_st.rx_hold = wr_data_in[3:0];
                        nxt_st.rx_hold_err = wr_data_in[epmi_pkg::RXN_ERR];
                        nxt_st.rx_hold_full = 1'b1;
                    end
                end
                epmi_pkg::REG_MII_DATA: begin
                    mem_we = 1'b1;
                    mem_waddr = wr_data_in[20:16];
                    mem_wdata = wr_data_in[15:0];
                end
                default: begin
                end
            endcase
        end
        // a management write wins the single ram port over software
        if (ev[epmi_pkg::EV_MD_WRITE]) begin
            mem_we = 1'b1;
            mem_waddr = st_ff.md_reg;
            mem_wdata = nxt_st.mii_last[15:0];
        end

        if (rd_in) begin
            case (addr_in)
                epmi_pkg::REG_CTRL: nxt_st.rd_data = DATA_W'(st_ff.ctrl);
                epmi_pkg::REG_STAT: nxt_st.rd_data = DATA_W'(st_ff.stat);
                epmi_pkg::REG_MASK: nxt_st.rd_data = DATA_W'(st_ff.mask);
                epmi_pkg::REG_PHY_ADDR: nxt_st.rd_data = DATA_W'(st_ff.phy_addr);
                epmi_pkg::REG_RX_NIB: nxt_st.rd_data = DATA_W'({st_ff.rx_pins.dv, st_ff.rx_hold_full,
                                                              st_ff.rx_hold_err, st_ff.rx_hold});
                epmi_pkg::REG_TX_NIB: nxt_st.rd_data = DATA_W'({st_ff.tx_cnt, 3'h0, st_ff.tx_prev_en,
                                                              st_ff.tx_last});
                epmi_pkg::REG_MII_DATA: nxt_st.rd_data = DATA_W'(st_ff.mii_last);
                default: nxt_st.rd_data = '0;
            endcase
        end
        // read clears the status, but an event in the same cycle survives
        if (rd_in && addr_in == epmi_pkg::REG_STAT) begin
            nxt_st.stat = ev;
        end else begin
            nxt_st.stat = st_ff.stat | ev;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '0;
            st_ff.ctrl <= epmi_pkg::CTRL_RESET;
            st_ff.stat <= epmi_pkg::STAT_RESET;
            st_ff.mask <= epmi_pkg::MASK_RESET;
            st_ff.phy_addr <= epmi_pkg::PHY_ADDR_RESET;
            st_ff.md_state <= epmi_pkg::MD_PRE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_out = st_ff.rd_data;
    assign irq_out = st_ff.irq;
    assign tx_clk_out = st_ff.lclk;
    assign rx_clk_out = st_ff.lclk;
    assign rx_pins_out = st_ff.rx_pins;
    assign carrier_out = st_ff.carrier;
    assign collision_out = st_ff.collision;
    assign ext_link_state_out = st_ff.link;
    assign mdio_out = st_ff.md_out;
    assign mdio_oe_out = st_ff.md_oe;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    a_rxer_needs_dv: assert property (rx_pins_out.er |-> rx_pins_out.dv)
        else $error("receive error without data valid");
    a_clk_keeps_running: assert property (1'b1 |-> ##[1:200] $changed(rx_clk_out))
        else $error("link clock stopped");
    a_rxd_on_fall: assert property ($changed(rx_pins_out) |-> !rx_clk_out && $past(rx_clk_out))
        else $error("receive pins changed away from falling edge");
    a_collision_forced: assert property (st_ff.ctrl[epmi_pkg::CTRL_COLLIDE] |=> collision_out)
        else $error("forced collision not shown");
    a_carrier_with_dv: assert property (rx_pins_out.dv |-> carrier_out)
        else $error("data valid without carrier");
    a_mdio_ta_zero: assert property ($rose(mdio_oe_out) |-> !mdio_out
        && st_ff.md_state == epmi_pkg::MD_TA)
        else $error("turnaround not driven low");
    a_mdio_release_end: assert property ($fell(mdio_oe_out) |-> st_ff.md_state == epmi_pkg::MD_PRE
        && $past(st_ff.md_cnt) == epmi_pkg::MD_DATA_LAST)
        else $error("management line released mid frame");
    a_link_event: assert property ($changed(ext_link_state_out) |-> st_ff.stat[epmi_pkg::EV_LINK])
        else $error("link change not flagged");
endmodule : epmi_phy

// ==== test/epmi_mac_model.sv ====
// Purpose: behavioural MAC driving the PHY model's transmit and management pins
// Assumes: 100 MHz ref clock; link inputs pass two flops before use
// Notes: management clock runs only inside frames, period 400 ns
`timescale 1ns/1ps
module epmi_mac_model (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic tx_clk_in,
    input wire logic rx_clk_in,
    input wire epmi_pkg::epmi_rx_pins_t rx_pins_in,
    input wire logic link_in,
    input wire logic mdio_line_in,
    output epmi_pkg::epmi_tx_pins_t tx_pins_out,
    output logic mdc_out,
    output logic mdio_drv_out,
    output logic mdio_oe_out
);
    logic [7:0] media_interface_select = 8'h04;
    logic [7:0] internal_phy_use_control = 8'h00;
    logic [2:0] s1_ff, s2_ff, s3_ff;
    logic [3:0] rx_last;
    logic rx_err;
    int link_events;
    int stalls = 0;
    wire logic active = media_interface_select[4:2] == 3'h1 && !internal_phy_use_control[2];
    initial begin
        tx_pins_out = '0;
        mdc_out = 1'b0;
        mdio_drv_out = 1'b1;
        mdio_oe_out = 1'b0;
    end
    // three flops: two to settle, the third only for edge detection
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            {s1_ff, s2_ff, s3_ff} <= '0;
            link_events <= 0;
            {rx_last, rx_err} <= '0;
        end else begin
            {s1_ff, s2_ff, s3_ff} <= {tx_clk_in, rx_clk_in, link_in, s1_ff, s2_ff};
            if (s2_ff[0] != s3_ff[0]) link_events <= link_events + 1;
            if (s2_ff[1] && !s3_ff[1] && rx_pins_in.dv) begin
                rx_last <= rx_pins_in.d;
                rx_err <= rx_pins_in.er;
            end
        end
    end
    task automatic send_frame(input logic [3:0] first, input int n);
        int k;
        for (int i = 0; i <= n; i++) begin
            k = 0;
            do begin
                @(posedge ref_clk_in);
                k++;
            end while (!(s3_ff[2] && !s2_ff[2]) && k < 1000);
            if (k >= 1000) stalls++;
            tx_pins_out.en <= active && i < n;
            tx_pins_out.d <= (i < n) ? first + 4'(i) : ~tx_pins_out.d;
        end
    endtask : send_frame
    // a write frame keeps the line for all 64 bits; a read hands it over after the address
    task automatic mdio_xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                             input logic [15:0] wd, output logic [15:0] data);
        logic [63:0] frm;
        frm = {32'hFFFF_FFFF, 2'h1, op, phy, rg, 2'h2, wd};
        data = 16'h0;
        for (int i = 0; i < 64; i++) begin
            mdc_out <= 1'b0;
            mdio_oe_out <= i < 46 || op == epmi_pkg::MD_OP_WRITE;
            mdio_drv_out <= frm[63 - i];
            repeat (20) @(posedge ref_clk_in);
            mdc_out <= 1'b1;
            if (i >= 48) data = {data[14:0], mdio_line_in};
            repeat (20) @(posedge ref_clk_in);
        end
        mdc_out <= 1'b0;
        @(posedge ref_clk_in);
    endtask : mdio_xfer
endmodule : epmi_mac_model

// ==== test/tb_epmi_phy.sv ====
// Purpose: register-level test of the PHY model against a behavioural MAC
// Assumes: 100 MHz ref clock, reset held 8 cycles
// Notes: frames run at 2.5 MHz so the MAC's synchronisers keep up
`timescale 1ns/1ps
module tb_epmi_phy;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, v;
    logic irq, tx_clk, rx_clk, carrier, collision, link, mdc, mdio_out, mdio_oe, mac_drv, mac_oe;
    logic [15:0] md;
    epmi_pkg::epmi_tx_pins_t tx_pins;
    epmi_pkg::epmi_rx_pins_t rx_pins;
    wire logic mdio_line = mdio_oe ? mdio_out : (mac_oe ? mac_drv : 1'b1);
    int failures = 0;
    int n_compared = 0;
    int cnt;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h40};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h0};
    logic [7:0] modes [3] = '{8'h18, 8'h1A, 8'h1C};
    int per [3] = '{4, 40, 400};
    epmi_phy dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr), .wr_data_in(wdata),
        .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .irq_out(irq), .tx_pins_in(tx_pins),
        .tx_clk_out(tx_clk), .rx_clk_out(rx_clk), .rx_pins_out(rx_pins), .carrier_out(carrier),
        .collision_out(collision), .ext_link_state_out(link), .mdc_in(mdc), .mdio_in(mdio_line),
        .mdio_out(mdio_out), .mdio_oe_out(mdio_oe));
    epmi_mac_model mac (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .tx_clk_in(tx_clk),
        .rx_clk_in(rx_clk), .rx_pins_in(rx_pins), .link_in(link), .mdio_line_in(mdio_line),
        .tx_pins_out(tx_pins), .mdc_out(mdc), .mdio_drv_out(mac_drv), .mdio_oe_out(mac_oe));
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1 v = rdata & m;
    endtask : rd_reg
    // counts ref cycles between two rises of the chosen link clock
    task automatic link_period(input logic use_rx, output int c);
        int k, e;
        logic p;
        {k, e, c, p} = '1;
        {k, e, c} = '0;
        while (e < 2 && k < 2000) begin
            @(posedge ref_clk_in);
            #1;
            if (e == 1) c++;
            if ((use_rx ? rx_clk : tx_clk) && !p) e++;
            p = use_rx ? rx_clk : tx_clk;
            k++;
        end
        if (k == 2000) begin
            failures++;
            print_verdict();
        end
    endtask : link_period
    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd_reg(ra[i], '1);
            check(v, rv[i]);
        end
        for (int m = 0; m < 3; m++) begin
            wr_reg(8'h00, {24'h0, modes[m]});
            link_period(1'b0, cnt);
            link_period(1'b0, cnt);
            check(cnt, per[m]);
            link_period(1'b1, cnt);
            check(cnt, per[m]);
            check({carrier, collision}, 2'h3);
        end
        wr_reg(8'h08, 32'h20);
        wr_reg(8'h00, 32'h3);
        repeat (6) @(posedge ref_clk_in);
        check({irq, link, 8'(mac.link_events)}, 10'h301);
        rd_reg(8'h04, 32'h20);
        check(v, 32'h20);
        @(posedge ref_clk_in);
        #1 check({irq, carrier, collision}, 3'h0);
        wr_reg(8'h08, 32'h0);
        wr_reg(8'h00, 32'h2);
        repeat (6) @(posedge ref_clk_in);
        check({irq, 8'(mac.link_events)}, 9'h002);
        wr_reg(8'h0C, 32'h1A);
        repeat (100) @(posedge ref_clk_in);
        check({mac.rx_err, mac.rx_last, rx_pins.dv}, 6'h34);
        rd_reg(8'h04, 32'h4);
        check(v, 32'h4);
        mac.send_frame(4'h5, 3);
        repeat (100) @(posedge ref_clk_in);
        rd_reg(8'h10, 32'hFF0F);
        check(v, 32'h0307);
        rd_reg(8'h04, 32'h3);
        check(v, 32'h3);
        mac.internal_phy_use_control = 8'h04;
        mac.send_frame(4'h9, 2);
        repeat (100) @(posedge ref_clk_in);
        rd_reg(8'h04, 32'h1);
        check(v, 32'h0);
        wr_reg(8'h18, 32'h0003_BEEF);
        mac.mdio_xfer(2'h2, 5'h02, 5'h03, 16'h0, md);
        check(md, 16'hBEEF);
        mac.mdio_xfer(2'h2, 5'h01, 5'h03, 16'h0, md);
        check(md, 16'hFFFF);
        wr_reg(8'h14, 32'h5);
        mac.mdio_xfer(2'h1, 5'h05, 5'h07, 16'h1234, md);
        rd_reg(8'h18, '1);
        check(v, 32'h0007_1234);
        mac.mdio_xfer(2'h2, 5'h05, 5'h07, 16'h0, md);
        check(md, 16'h1234);
        mac.mdio_xfer(2'h2, 5'h05, 5'h03, 16'h0, md);
        check(md, 16'hBEEF);
        rd_reg(8'h04, 32'h18);
        check(v, 32'h18);
        check(mac.stalls, 32'h0);
        print_verdict();
    end
endmodule : tb_epmi_phy
